// ==== src/spi_pin_sync.v ====
// two-stage synchroniser for the serial port pins
`timescale 1ns/1ps
`default_nettype none

module spi_pin_sync (
  input wire clock_i,
  input wire rst_b_i,
  input wire [3:0] d_i,
  output wire [3:0] q_o
);

  reg [3:0] stage1; // first stage, read only by stage2
  reg [3:0] stage2; // safe to use

  // plain double flop per bit; ss resets high so it reads deselected,
  // sck resets low to match the edge finder, so no false edge after reset
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1 <= 4'h8;
      stage2 <= 4'h8;
    end else begin
      stage1 <= d_i;
      stage2 <= stage1;
    end
  end

  assign q_o = stage2;

endmodule

`default_nettype wire

// ==== src/spi_port.v ====
// byte-wide serial peripheral port, master or slave, with apb register access
//
// Notes on behaviour
// - master drives sck, rate and cpol/cpha
// - master and enable kept only while select high
// - master data write loads shifter, msb first
// - byte end sets done flag, maybe interrupt
// - master done clears: status access, data read
// - data writes ignored until status read
// - slave data write loads shifter onto miso
// - slave transfer starts on master clock edges
// - slave done clears: status access, data access
// - select low as master: fault, disable
// - fault clears: status read, then ctrl write
// - fault refuses enable and master set
// - byte while done set gives overrun
// - overrun keeps first byte, drops later ones
// - status read clears overrun
// - data write mid-transfer dropped, collision flag
// - read buffer is synchronous to cpu
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "spi_port_map.vh"
`default_nettype none

module spi_port (
  input wire clock_i,
  input wire rst_b_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire cpu_irq_mask_i,
  output wire irq_o,
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe_o,
  input wire mosi_i,
  output wire mosi_o,
  output wire mosi_oe_o,
  input wire miso_i,
  output wire miso_o,
  output wire miso_oe_o,
  input wire ss_b_i
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte address of a register index
  function [7:0] addr_of;
    input [5:0] idx;
    begin
      addr_of = {idx, 2'b00};
    end
  endfunction

  // sck half period in clock cycles for a rate code
  function [9:0] half_of;
    input [2:0] rate;
    begin
      half_of = `SPI_HALF_BASE << rate;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [3:0] pins_s; // synced ss, sck, mosi, miso
  wire ss_s; // synced select, active low on pin
  wire sck_s; // synced serial clock
  wire mosi_s; // synced mosi
  wire miso_s; // synced miso

  spi_pin_sync u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i({ss_b_i, sck_i, mosi_i, miso_i}),
    .q_o(pins_s)
  );

  assign ss_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0] ctrl; // ctrl_reg
  reg xfer_done_flag; // byte finished
  reg write_collision_flag; // write hit a busy shifter
  reg overrun_flag; // byte lost
  reg mode_fault_flag; // select dropped while master
  reg output_disable; // keep pins undriven
  reg sw_select_manage; // select from software
  reg sw_select_level; // software select level
  reg [7:0] rx_buf; // read buffer, cpu side
  reg [7:0] tx; // transmit shifter
  reg [7:0] rx; // receive shifter
  reg [2:0] bit_cnt; // trailing edges seen this byte
  reg busy; // transfer in progress
  reg first; // no leading edge yet this byte
  reg sck_int; // master clock level
  reg sck_d; // last synced sck, slave edge finder
  reg [9:0] div_cnt; // master half period count
  reg x_arm_acc; // status accessed while done set
  reg x_arm_rd; // status read while done set
  reg m_arm; // status read while fault set
  reg w_arm; // status read while collision set

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire acc; // access phase edge
  wire hit_d; // data_reg selected
  wire hit_c; // ctrl_reg selected
  wire hit_s; // ctrl_status_reg selected
  wire wr_d; // data write
  wire rd_d; // data read
  wire wr_c; // ctrl write
  wire wr_s; // status write
  wire rd_s; // status read

  assign acc = psel_i & penable_i;
  assign hit_d = (paddr_i == addr_of(`SPI_IDX_DATA));
  assign hit_c = (paddr_i == addr_of(`SPI_IDX_CTRL));
  assign hit_s = (paddr_i == addr_of(`SPI_IDX_STAT));
  assign wr_d = acc & pwrite_i & hit_d;
  assign rd_d = acc & ~pwrite_i & hit_d;
  assign wr_c = acc & pwrite_i & hit_c;
  assign wr_s = acc & pwrite_i & hit_s;
  assign rd_s = acc & ~pwrite_i & hit_s;

  // zero wait states; unmapped address answers with an error
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~(hit_d | hit_c | hit_s);

  ////////////////////////////////////////////////////////////////////////////
  // mode and edge logic

  wire cpol; // idle clock level
  wire cpha; // sample on trailing edge when set
  wire master_on; // master and enabled
  wire slave_on; // slave and enabled
  wire ss_eff; // effective select seen by master
  wire fault; // select low while master
  wire slave_sel; // slave picked by external master
  wire tick; // master half period over
  wire lead; // leading clock edge
  wire trail; // trailing clock edge
  wire in_bit; // bit arriving from the far side
  wire sample; // capture edge
  wire shift_e; // launch edge
  wire done; // last trailing edge of the byte
  wire [7:0] next_rx; // receive shifter after a capture
  wire [7:0] rx_final; // completed byte
  wire wr_blocked; // data write ignored while done unread
  wire wr_ok; // data write that reaches the shifter

  assign cpol = ctrl[`SPI_C_CPOL];
  assign cpha = ctrl[`SPI_C_CPHA];
  assign master_on = ctrl[`SPI_C_MASTER] & ctrl[`SPI_C_PERIPH_EN];
  assign slave_on = ~ctrl[`SPI_C_MASTER] & ctrl[`SPI_C_PERIPH_EN];
  assign ss_eff = sw_select_manage ? sw_select_level : ss_s;
  assign fault = ctrl[`SPI_C_MASTER] & ~ss_eff;
  assign slave_sel = slave_on & ~ss_s;
  assign tick = busy & master_on & (div_cnt == 10'h000);

  // slave edges come from the synced pin, master edges from the divider
  assign lead = (tick & (sck_int == cpol)) |
                (slave_sel & (sck_s != sck_d) & (sck_d == cpol));
  assign trail = (tick & (sck_int != cpol)) |
                 (slave_sel & (sck_s != sck_d) & (sck_d != cpol));
  assign in_bit = master_on ? miso_s : mosi_s;
  assign sample = cpha ? trail : lead;
  assign shift_e = cpha ? (lead & ~first) : trail;
  assign done = trail & (bit_cnt == 3'd7);
  assign next_rx = {rx[6:0], in_bit};
  assign rx_final = cpha ? next_rx : rx;
  assign wr_blocked = xfer_done_flag & ~x_arm_rd;
  assign wr_ok = wr_d & ~busy & ~wr_blocked;

  ////////////////////////////////////////////////////////////////////////////
  // shift engine

  // one engine for both modes; the mode picks the edge source, the input pin and what starts a byte
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx <= `SPI_DATA_RESET;
      rx <= `SPI_DATA_RESET;
      bit_cnt <= 3'd0;
      busy <= 1'b0;
      first <= 1'b1;
      sck_int <= 1'b0;
      sck_d <= 1'b0;
      div_cnt <= 10'h000;
    end else begin
      sck_d <= sck_s;
      if (!ctrl[`SPI_C_PERIPH_EN] || fault) begin
        // disabled or faulted: abandon the byte, clock to idle
        busy <= 1'b0;
        bit_cnt <= 3'd0;
        first <= 1'b1;
        sck_int <= cpol;
        if (wr_ok) begin
          tx <= pwdata_i[7:0];
        end
      end else if (slave_on && ss_s) begin
        // deselected slave: ready for the next byte, shifter loadable
        busy <= 1'b0;
        bit_cnt <= 3'd0;
        first <= 1'b1;
        if (wr_ok) begin
          tx <= pwdata_i[7:0];
        end
      end else if (!busy) begin
        sck_int <= cpol;
        if (wr_ok) begin
          tx <= pwdata_i[7:0];
          if (master_on) begin
            busy <= 1'b1;
            first <= 1'b1;
            div_cnt <= half_of({ctrl[`SPI_C_RATE2], ctrl[`SPI_C_RATE1],
                                ctrl[`SPI_C_RATE0]}) - 10'h001;
          end
        end else if (slave_sel && lead) begin
          // first clock edge from the master starts a slave byte
          busy <= 1'b1;
          first <= 1'b0;
          if (!cpha) begin
            rx <= next_rx;
          end
        end
      end else begin
        // master clock divider
        if (master_on) begin
          if (tick) begin
            sck_int <= ~sck_int;
            div_cnt <= half_of({ctrl[`SPI_C_RATE2], ctrl[`SPI_C_RATE1],
                                ctrl[`SPI_C_RATE0]}) - 10'h001;
          end else begin
            div_cnt <= div_cnt - 10'h001;
          end
        end
        if (lead) begin
          first <= 1'b0;
        end
        if (sample) begin
          rx <= next_rx;
        end
        if (shift_e) begin
          tx <= {tx[6:0], 1'b0}; // msb first
        end
        if (trail) begin
          bit_cnt <= bit_cnt + 3'd1;
        end
        if (done) begin
          busy <= 1'b0;
          first <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // fault forces enable and master low; writes cannot set them during a fault
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= `SPI_CTRL_RESET;
    end else begin
      if (wr_c) begin
        ctrl <= pwdata_i[7:0];
        if (mode_fault_flag && !m_arm) begin
          ctrl[`SPI_C_PERIPH_EN] <= 1'b0;
          ctrl[`SPI_C_MASTER] <= 1'b0;
        end
      end
      if (fault) begin
        ctrl[`SPI_C_PERIPH_EN] <= 1'b0;
        ctrl[`SPI_C_MASTER] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags and clearing sequences

  // every flag: a set in the same cycle as its clear wins
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfer_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      overrun_flag <= 1'b0;
      mode_fault_flag <= 1'b0;
      output_disable <= 1'b0;
      sw_select_manage <= 1'b0;
      sw_select_level <= 1'b0;
      x_arm_acc <= 1'b0;
      x_arm_rd <= 1'b0;
      m_arm <= 1'b0;
      w_arm <= 1'b0;
      rx_buf <= `SPI_DATA_RESET;
    end else begin
      if (wr_s) begin
        output_disable <= pwdata_i[`SPI_S_OUT_DIS];
        sw_select_manage <= pwdata_i[`SPI_S_SW_MANAGE];
        sw_select_level <= pwdata_i[`SPI_S_SW_LEVEL];
      end
      // transfer done: master clears on data read, slave on any data access
      if ((rd_s || wr_s) && xfer_done_flag) begin
        x_arm_acc <= 1'b1;
      end
      if (rd_s && xfer_done_flag) begin
        x_arm_rd <= 1'b1;
      end
      if (done) begin
        xfer_done_flag <= 1'b1;
        x_arm_acc <= 1'b0;
        x_arm_rd <= 1'b0;
        if (xfer_done_flag) begin
          overrun_flag <= 1'b1;
        end else begin
          rx_buf <= rx_final;
        end
      end else if (x_arm_acc && (rd_d || (wr_d && !ctrl[`SPI_C_MASTER]))) begin
        xfer_done_flag <= 1'b0;
        x_arm_acc <= 1'b0;
        x_arm_rd <= 1'b0;
      end else if (rd_s) begin
        overrun_flag <= 1'b0;
      end
      if (done && rd_s && !xfer_done_flag) begin
        overrun_flag <= 1'b0;
      end
      // mode fault
      if (fault) begin
        mode_fault_flag <= 1'b1;
        m_arm <= 1'b0;
      end else if (m_arm && wr_c) begin
        mode_fault_flag <= 1'b0;
        m_arm <= 1'b0;
      end else if (rd_s && mode_fault_flag) begin
        m_arm <= 1'b1;
      end
      // write collision, no interrupt
      if (wr_d && busy) begin
        write_collision_flag <= 1'b1;
        w_arm <= 1'b0;
      end else if (w_arm && (rd_d || wr_d)) begin
        write_collision_flag <= 1'b0;
        w_arm <= 1'b0;
      end else if (rd_s && write_collision_flag) begin
        w_arm <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (hit_d) begin
        prdata_o <= {24'h00_0000, rx_buf};
      end else if (hit_c) begin
        prdata_o <= {24'h00_0000, ctrl};
      end else if (hit_s) begin
        prdata_o <= {24'h00_0000, xfer_done_flag, write_collision_flag,
                     overrun_flag, mode_fault_flag, 1'b0, output_disable,
                     sw_select_manage, sw_select_level};
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and interrupt

  // collision is status only and never reaches the request
  assign irq_o = ctrl[`SPI_C_IRQ_EN] & ~cpu_irq_mask_i &
                 (xfer_done_flag | mode_fault_flag | overrun_flag);
  assign sck_o = sck_int;
  assign sck_oe_o = master_on & ~output_disable;
  assign mosi_o = tx[7];
  assign mosi_oe_o = master_on & ~output_disable;
  assign miso_o = tx[7];
  assign miso_oe_o = slave_sel & ~output_disable;

endmodule

`default_nettype wire

// ==== src/spi_port_map.vh ====
// register map, field positions, reset values and timing counts of the serial port
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH

// register indices; byte address is four times the index
`define SPI_IDX_DATA 6'h21
`define SPI_IDX_CTRL 6'h22
`define SPI_IDX_STAT 6'h23

// apb address width in bits
`define SPI_AW 8

// ctrl_reg fields
`define SPI_C_IRQ_EN 7
`define SPI_C_PERIPH_EN 6
`define SPI_C_RATE2 5
`define SPI_C_MASTER 4
`define SPI_C_CPOL 3
`define SPI_C_CPHA 2
`define SPI_C_RATE1 1
`define SPI_C_RATE0 0
`define SPI_CTRL_RESET 8'h00

// ctrl_status_reg fields
`define SPI_S_XFER_DONE 7
`define SPI_S_WRITE_COLLISION_FLAG 6
`define SPI_S_OVR 5
`define SPI_S_MODE_FAULT_FLAG 4
`define SPI_S_OUT_DIS 2
`define SPI_S_SW_MANAGE 1
`define SPI_S_SW_LEVEL 0
`define SPI_STAT_RESET 8'h00

// master clock: half period of sck is this many cycles shifted left by rate_select
`define SPI_HALF_BASE 10'h004
`define SPI_DATA_RESET 8'h00

`endif

// ==== testbench/spi_far_slave.sv ====
// external slave model, clock low at idle, sample on rise, launch on fall
`timescale 1ns/1ps
`default_nettype none

module spi_far_slave (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_b_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o,
  output logic got_o
);
  logic [7:0] tx = 8'h00; // outgoing byte, msb at the line
  logic [2:0] n = 3'h0; // bits taken in this byte
  // released line shows the inverse so a stale bit never matches by luck
  assign miso_o = sel_b_i ? ~tx[7] : tx[7];
  // load first byte on select
  always @(negedge sel_b_i) tx <= tx_i;
  // sample on the leading edge, same polarity and phase as the master
  // a deselected slave ignores the clock
  always @(posedge sck_i) begin
    if (!sel_b_i) begin
      rx_o <= {rx_o[6:0], mosi_i};
      n <= n + 3'h1;
      got_o <= (n == 3'h7);
    end
  end
  // launch on the trailing edge; the next byte is loaded after bit 0
  always @(negedge sck_i) begin
    if (!sel_b_i) begin
      if (n == 3'h0) tx <= tx_i;
      else tx <= {tx[6:0], 1'b0};
    end
  end
endmodule

`default_nettype wire

// ==== testbench/spi_port_sva.sv ====
// concurrent checks on the serial port's bus and pin ports
`timescale 1ns/1ps
`default_nettype none

module spi_port_sva (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic cpu_irq_mask_i,
  input wire logic irq_o,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic mosi_oe_o,
  input wire logic miso_oe_o,
  input wire logic ss_b_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////
  // bus side: zero wait, unmapped refused, read data steady
  AST_PREADY: assert property (pready_o)
    else $error("pready low");
  AST_SLVERR: assert property (psel_i && penable_i |->
    pslverr_o == !(paddr_i inside {8'h84, 8'h88, 8'h8c})) else $error("bad pslverr");
  AST_RD_UPPER: assert property (prdata_o[31:8] == 24'h00_0000)
    else $error("read upper bits set");
  AST_RD_HOLD: assert property (!(psel_i && !penable_i && !pwrite_i) |=>
    $stable(prdata_o)) else $error("read data moved");
  AST_IRQ_MASK: assert property (cpu_irq_mask_i |-> !irq_o)
    else $error("irq while masked");
  ////////////////////////////////////////////////////////////////////////////
  // pin side: one driver per role, clock half period at least four cycles
  AST_SCK_OE: assert property (sck_oe_o |-> mosi_oe_o && !miso_oe_o)
    else $error("master drives miso");
  AST_MISO_OE: assert property (ss_b_i [*4] |-> !miso_oe_o)
    else $error("miso driven unselected");
  AST_SCK_HALF: assert property (sck_oe_o && $changed(sck_o) |=>
    ($stable(sck_o) || !sck_oe_o) [*3]) else $error("sck half too short");
endmodule

bind spi_port spi_port_sva chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_irq_mask_i(cpu_irq_mask_i),
  .irq_o(irq_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o),
  .miso_oe_o(miso_oe_o), .ss_b_i(ss_b_i));

`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench: apb driver, far slave, queued read and byte checks
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, tx = 8'h00, d1, d2, d3, p1, p2;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_d625, prdata;
  logic mask = 1'b0, ss_b = 1'b1, sel_b = 1'b1, got, far_miso;
  logic msck = 1'b0, mmosi = 1'b0; // bench as external master in slave tests
  logic [7:0] s1, s2, b1, b2, sin; // slave bytes out, bytes in, bits seen on miso
  wire logic pready, pslverr, irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe;
  wire logic [7:0] far_rx;
  logic [7:0] q[$], qb[$]; // expected read bytes, expected far-side bytes
  int error_cnt = 0, tests_run = 0, cyc = 0;
  // bench master drives sck and mosi when the port does not; both idle low
  wire logic sck_w = sck_oe ? sck : msck;
  wire logic mosi_w = mosi_oe ? mosi : mmosi;
  wire logic miso_w = miso_oe ? miso : far_miso;

  spi_port uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cpu_irq_mask_i(mask), .irq_o(irq),
    .sck_i(sck_w), .sck_o(sck), .sck_oe_o(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi),
    .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso), .miso_oe_o(miso_oe),
    .ss_b_i(ss_b));
  spi_far_slave far (.sck_i(sck_w), .mosi_i(mosi_w), .sel_b_i(sel_b), .tx_i(tx),
    .miso_o(far_miso), .rx_o(far_rx), .got_o(got));

  always #2.5 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer; a read notes its expected byte
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    if (!w) q.push_back(d);
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask
  task wait_irq;
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clock_i);
  endtask
  // one byte as external master, 160 ns clock, idle low; ph picks the phase
  task slave_byte(input logic ph, input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      if (!ph) mmosi <= b[i];
      repeat (16) @(posedge clock_i);
      msck <= 1'b1;
      if (ph) mmosi <= b[i];
      else r = {r[6:0], miso_w};
      repeat (16) @(posedge clock_i);
      msck <= 1'b0;
      if (ph) r = {r[6:0], miso_w};
    end
  endtask
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [7:0] rnd;
    seed = lfsr(seed);
    rnd = seed[7:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // read results, taken at the completing edge
  always @(posedge clock_i) begin
    if (psel && penable && !pwrite && pready)
      check(prdata, {24'h00_0000, q.size() ? q.pop_front() : ~prdata[7:0]});
  end
  // far-side bytes; an unexpected byte is a mismatch
  always @(posedge got) begin
    #1;
    check({24'h00_0000, far_rx},
          qb.size() ? {24'h00_0000, qb.pop_front()} : 32'h0000_0100);
  end
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    d1 = rnd();
    d2 = rnd();
    d3 = rnd();
    p1 = rnd();
    p2 = rnd();
    s1 = rnd();
    s2 = rnd();
    b1 = rnd();
    b2 = rnd();
    // far byte settles well before select falls, so the load never races it
    tx <= p1;
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    sel_b <= 1'b0;
    @(posedge clock_i);
    apb(0, 8'h8c, 8'h00);
    apb(0, 8'h88, 8'h00);
    apb(0, 8'h90, 8'h00);
    $display("test reset done");
    // rate 2, then select managed high, then enable master with irq
    apb(1, 8'h88, 8'h02);
    apb(1, 8'h8c, 8'h03);
    apb(1, 8'h88, 8'hd2);
    qb.push_back(d1);
    apb(1, 8'h84, d1);
    tx <= p2;
    apb(1, 8'h84, 8'h5a);
    wait_irq();
    check({31'h0, irq}, 32'h0000_0001);
    apb(0, 8'h8c, 8'hc3);
    apb(0, 8'h84, p1);
    apb(0, 8'h8c, 8'h03);
    check({31'h0, irq}, 32'h0000_0000);
    $display("test master done");
    qb.push_back(d2);
    apb(1, 8'h84, d2);
    tx <= rnd();
    wait_irq();
    apb(1, 8'h84, 8'h3c);
    repeat (300) @(posedge clock_i);
    apb(0, 8'h8c, 8'h83);
    qb.push_back(d3);
    apb(1, 8'h84, d3);
    repeat (300) @(posedge clock_i);
    apb(0, 8'h8c, 8'ha3);
    apb(0, 8'h84, p2);
    apb(0, 8'h8c, 8'h03);
    $display("test overrun done");
    apb(1, 8'h8c, 8'h00);
    ss_b <= 1'b0;
    repeat (10) @(posedge clock_i);
    apb(0, 8'h88, 8'h82);
    check({31'h0, irq}, 32'h0000_0001);
    mask <= 1'b1;
    @(posedge clock_i);
    #1 check({31'h0, irq}, 32'h0000_0000);
    mask <= 1'b0;
    apb(1, 8'h88, 8'hd2);
    apb(0, 8'h88, 8'h82);
    ss_b <= 1'b1;
    repeat (4) @(posedge clock_i);
    apb(0, 8'h8c, 8'h10);
    apb(1, 8'h88, 8'hd2);
    apb(0, 8'h8c, 8'h00);
    apb(0, 8'h88, 8'hd2);
    $display("test fault done");
    // slave, phase 0: status first, then enable; select low per byte
    sel_b <= 1'b1;
    apb(1, 8'h8c, 8'h00);
    apb(1, 8'h88, 8'h40);
    apb(1, 8'h84, s1);
    ss_b <= 1'b0;
    repeat (4) @(posedge clock_i);
    slave_byte(1'b0, b1, sin);
    repeat (8) @(posedge clock_i);
    ss_b <= 1'b1;
    check({24'h00_0000, sin}, {24'h00_0000, s1});
    apb(0, 8'h8c, 8'h80);
    apb(1, 8'h84, s2);
    apb(0, 8'h8c, 8'h00);
    apb(0, 8'h84, b1);
    // slave, phase 1: select held low across the byte
    apb(1, 8'h88, 8'h44);
    ss_b <= 1'b0;
    repeat (4) @(posedge clock_i);
    slave_byte(1'b1, b2, sin);
    repeat (8) @(posedge clock_i);
    check({24'h00_0000, sin}, {24'h00_0000, s2});
    apb(0, 8'h8c, 8'h80);
    apb(0, 8'h84, b2);
    apb(0, 8'h8c, 8'h00);
    $display("test slave done");
    print_verdict();
  end
endmodule

`default_nettype wire
